// >>> hdl/smpl_pkg.sv
`default_nettype none
package smpl_pkg;
	// ==================================================
	// register offsets
	localparam logic [7:0] ADDR_PAUSE_LIMIT = 8'hbd;
	localparam logic [7:0] ADDR_FIBER_THRESH = 8'hc0;
	localparam logic [7:0] ADDR_TAG_INSERT = 8'hc2;
	localparam logic [7:0] ADDR_PWR_LED = 8'hc3;
	localparam logic [7:0] ADDR_SLEEP_DELAY = 8'hc4;
	// ==================================================
	// values after reset
	localparam logic [7:0] RST_PAUSE_LIMIT = 8'h00;
	localparam logic [7:0] RST_FIBER_THRESH = 8'h00;
	localparam logic [7:0] RST_TAG_INSERT = 8'h00;
	localparam logic [7:0] RST_PWR_LED = 8'h00;
	localparam logic [7:0] RST_SLEEP_DELAY = 8'h50;
	// ==================================================
	// field positions
	localparam int FIB_P2_BIT = 7;
	localparam int FIB_P1_BIT = 6;
	localparam logic [7:0] FIB_WMASK = 8'hc0;
	localparam logic [7:0] TAG_WMASK = 8'h3f;
	localparam int TAG_S1_D2 = 5;
	localparam int TAG_S1_D3 = 4;
	localparam int TAG_S2_D1 = 3;
	localparam int TAG_S2_D3 = 2;
	localparam int TAG_S3_D1 = 1;
	localparam int TAG_S3_D2 = 0;
	localparam int PWR_CPU_PD_BIT = 7;
	localparam int PWR_SW_PD_BIT = 6;
	localparam int PWR_LED_MSB = 5;
	localparam int PWR_LED_LSB = 4;
	localparam int PWR_LED_DBG_BIT = 3;
	localparam int PWR_PLL_PD_BIT = 2;
	localparam int PWR_MODE_MSB = 1;
	localparam int PWR_MODE_LSB = 0;
	// ==================================================
	// timing
	localparam int unsigned CLK_KHZ = 250_000;
	localparam int unsigned PAUSE_LIMIT_MS = 160;
	localparam int unsigned SLEEP_UNIT_MS = 20;
	localparam int unsigned PAUSE_LIMIT_CYC = PAUSE_LIMIT_MS * CLK_KHZ;
	localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_MS * CLK_KHZ;
	// ==================================================
	// enumerations
	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_ENERGY_DETECT = 2'b01,
		PM_SW_POWER_DOWN = 2'b10,
		PM_POWER_SAVING = 2'b11
	} smpl_pm_t;
	typedef enum logic [1:0] {
		LED_LINKACT_SPEED = 2'b00,
		LED_LINK_ACT = 2'b01,
		LED_LINKACT_DUPLEX = 2'b10,
		LED_LINK_DUPLEX = 2'b11
	} smpl_led_t;
	typedef enum logic {
		SL_AWAKE = 1'b0,
		SL_ASLEEP = 1'b1
	} smpl_sleep_t;
endpackage : smpl_pkg
`default_nettype wire

// >>> hdl/smpl_sleep_if.sv
`default_nettype none
interface smpl_sleep_if;
	logic energy_detect_mode;
	logic [7:0] delay_units;
	logic energy;
	logic asleep;
	modport ctrl (
		output energy_detect_mode,
		output delay_units,
		output energy,
		input asleep
	);
	modport timer (
		input energy_detect_mode,
		input delay_units,
		input energy,
		output asleep
	);
endinterface : smpl_sleep_if
`default_nettype wire

// >>> hdl/smpl_sleep_timer.sv
`default_nettype none
module smpl_sleep_timer #(
	parameter int unsigned UNIT_CYCLES = smpl_pkg::SLEEP_UNIT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control from the register bank
	smpl_sleep_if.timer sif
);
	// ==================================================
	// idle interval counting
	logic [31:0] unit_cnt;
	logic [7:0] units_done;
	smpl_pkg::smpl_sleep_t state;
	logic idle;

	assign idle = sif.energy_detect_mode && !sif.energy;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unit_cnt <= '0;
			units_done <= '0;
		end else if (!idle) begin
			// any energy restarts the interval
			unit_cnt <= '0;
			units_done <= '0;
		end else if (state == smpl_pkg::SL_AWAKE) begin
			if (unit_cnt == 32'(UNIT_CYCLES - 1)) begin
				unit_cnt <= '0;
				if (units_done != 8'hff) begin
					units_done <= units_done + 8'h01;
				end
			end else begin
				unit_cnt <= unit_cnt + 32'd1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= smpl_pkg::SL_AWAKE;
		end else begin
			case (state)
				smpl_pkg::SL_AWAKE: begin
					if (idle && units_done >= sif.delay_units) begin
						state <= smpl_pkg::SL_ASLEEP;
					end
				end
				smpl_pkg::SL_ASLEEP: begin
					if (!idle) begin
						state <= smpl_pkg::SL_AWAKE;
					end
				end
				default: begin
					state <= smpl_pkg::SL_AWAKE;
				end
			endcase
		end
	end

	assign sif.asleep = (state == smpl_pkg::SL_ASLEEP);

	// ==================================================
	// checks
	chk_sleep_entry_count: assert property (@(posedge clk) disable iff (rst)
		$rose(sif.asleep) |-> $past(units_done) >= $past(sif.delay_units) && $past(idle))
		else $error("low power entered before the idle interval ran out");
	chk_idle_restart: assert property (@(posedge clk) disable iff (rst)
		sif.energy |=> unit_cnt == 32'd0 && units_done == 8'd0)
		else $error("idle count not restarted by energy");
	chk_wake_on_energy: assert property (@(posedge clk) disable iff (rst)
		sif.asleep && sif.energy |=> !sif.asleep)
		else $error("device stayed asleep with energy present");
	chk_sleep_only_ed: assert property (@(posedge clk) disable iff (rst)
		!sif.energy_detect_mode |=> !sif.asleep)
		else $error("low power state outside energy detect mode");
	cov_sleep_entered: cover property (@(posedge clk) disable iff (rst) $rose(sif.asleep));
endmodule : smpl_sleep_timer
`default_nettype wire

// >>> hdl/smpl_switch_misc_ctrl.sv
`default_nettype none
module smpl_switch_misc_ctrl #(
	parameter int unsigned PAUSE_LIMIT_CYCLES = smpl_pkg::PAUSE_LIMIT_CYC,
	parameter int unsigned SLEEP_UNIT_CYCLES = smpl_pkg::SLEEP_UNIT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// flow control
	input wire logic pause_active,
	output logic flow_ctrl_invalidate_req,
	// fiber signal detect
	output logic fiber_thresh_high_p1,
	output logic fiber_thresh_high_p2,
	// default tag insertion
	output logic [5:0] tag_insert_map,
	input wire logic qry_valid,
	input wire logic [1:0] qry_src_port,
	input wire logic [1:0] qry_egress_port,
	input wire logic qry_untagged,
	output logic qry_insert,
	// power management
	output logic cpu_if_clk_pd_en,
	output logic switch_clk_pd_en,
	output logic pll_pd_en,
	output logic [1:0] power_mode,
	input wire logic energy_detected,
	output logic low_power_state,
	// led sources and pins
	input wire logic link_up,
	input wire logic activity,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic energy_stretched,
	input wire logic device_ready,
	output logic led_pin_first,
	output logic led_pin_second
);
	// ==================================================
	// register storage
	logic [7:0] pause_off_limit_enable;
	logic [7:0] fiber_threshold_select;
	logic [7:0] source_vlan_tag_insert;
	logic [7:0] power_and_led_control;
	logic [7:0] sleep_delay;

	function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] r_pause,
			input logic [7:0] r_fib, input logic [7:0] r_tag, input logic [7:0] r_pwr,
			input logic [7:0] r_slp);
		case (addr)
			smpl_pkg::ADDR_PAUSE_LIMIT: reg_read = r_pause;
			smpl_pkg::ADDR_FIBER_THRESH: reg_read = r_fib & smpl_pkg::FIB_WMASK;
			smpl_pkg::ADDR_TAG_INSERT: reg_read = r_tag & smpl_pkg::TAG_WMASK;
			smpl_pkg::ADDR_PWR_LED: reg_read = r_pwr;
			smpl_pkg::ADDR_SLEEP_DELAY: reg_read = r_slp;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// tag insertion decision for one source/egress pair
	function automatic logic tag_decode(input logic [5:0] map, input logic [1:0] src,
			input logic [1:0] dst);
		case ({src, dst})
			4'b01_10: tag_decode = map[smpl_pkg::TAG_S1_D2];
			4'b01_11: tag_decode = map[smpl_pkg::TAG_S1_D3];
			4'b10_01: tag_decode = map[smpl_pkg::TAG_S2_D1];
			4'b10_11: tag_decode = map[smpl_pkg::TAG_S2_D3];
			4'b11_01: tag_decode = map[smpl_pkg::TAG_S3_D1];
			4'b11_10: tag_decode = map[smpl_pkg::TAG_S3_D2];
			default: tag_decode = 1'b0;
		endcase
	endfunction : tag_decode

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pause_off_limit_enable <= smpl_pkg::RST_PAUSE_LIMIT;
			fiber_threshold_select <= smpl_pkg::RST_FIBER_THRESH;
			source_vlan_tag_insert <= smpl_pkg::RST_TAG_INSERT;
			power_and_led_control <= smpl_pkg::RST_PWR_LED;
			sleep_delay <= smpl_pkg::RST_SLEEP_DELAY;
		end else if (reg_wr) begin
			case (reg_addr)
				smpl_pkg::ADDR_PAUSE_LIMIT: pause_off_limit_enable <= reg_wdata;
				smpl_pkg::ADDR_FIBER_THRESH: begin
					// reserved low bits stay zero
					fiber_threshold_select <= reg_wdata & smpl_pkg::FIB_WMASK;
				end
				smpl_pkg::ADDR_TAG_INSERT: begin
					source_vlan_tag_insert <= reg_wdata & smpl_pkg::TAG_WMASK;
				end
				smpl_pkg::ADDR_PWR_LED: power_and_led_control <= reg_wdata;
				smpl_pkg::ADDR_SLEEP_DELAY: sleep_delay <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= reg_read(reg_addr, pause_off_limit_enable, fiber_threshold_select,
				source_vlan_tag_insert, power_and_led_control, sleep_delay);
		end
	end

	// ==================================================
	// pause-off iteration limit
	logic pause_limit_en;
	logic [31:0] pause_cnt;
	logic pause_fired;

	assign pause_limit_en = |pause_off_limit_enable;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pause_cnt <= '0;
			pause_fired <= 1'b0;
			flow_ctrl_invalidate_req <= 1'b0;
		end else if (!pause_limit_en || !pause_active) begin
			pause_cnt <= '0;
			pause_fired <= 1'b0;
			flow_ctrl_invalidate_req <= 1'b0;
		end else if (pause_cnt == 32'(PAUSE_LIMIT_CYCLES - 1)) begin
			// one request per uninterrupted pause stretch
			flow_ctrl_invalidate_req <= !pause_fired;
			pause_fired <= 1'b1;
		end else begin
			pause_cnt <= pause_cnt + 32'd1;
			flow_ctrl_invalidate_req <= 1'b0;
		end
	end

	// ==================================================
	// fiber thresholds and tag insertion
	assign fiber_thresh_high_p2 = fiber_threshold_select[smpl_pkg::FIB_P2_BIT];
	assign fiber_thresh_high_p1 = fiber_threshold_select[smpl_pkg::FIB_P1_BIT];
	assign tag_insert_map = source_vlan_tag_insert[5:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			qry_insert <= 1'b0;
		end else if (qry_valid) begin
			// tagged frames never get a second tag
			qry_insert <= qry_untagged && tag_decode(tag_insert_map, qry_src_port,
				qry_egress_port);
		end
	end

	// ==================================================
	// power management
	smpl_sleep_if sif ();

	assign cpu_if_clk_pd_en = power_and_led_control[smpl_pkg::PWR_CPU_PD_BIT];
	assign switch_clk_pd_en = power_and_led_control[smpl_pkg::PWR_SW_PD_BIT];
	assign pll_pd_en = power_and_led_control[smpl_pkg::PWR_PLL_PD_BIT];
	assign power_mode = power_and_led_control[smpl_pkg::PWR_MODE_MSB:smpl_pkg::PWR_MODE_LSB];
	assign sif.energy_detect_mode = (power_mode == smpl_pkg::PM_ENERGY_DETECT);
	assign sif.delay_units = sleep_delay;
	assign sif.energy = energy_detected;
	assign low_power_state = sif.asleep;

	smpl_sleep_timer #(
		.UNIT_CYCLES(SLEEP_UNIT_CYCLES)
	) u_sleep (
		.clk(clk),
		.rst(rst),
		.sif(sif)
	);

	// ==================================================
	// led pins
	logic [1:0] led_mode;
	logic led_dbg;
	logic link_act;
	logic next_led_first;
	logic next_led_second;

	assign led_mode = power_and_led_control[smpl_pkg::PWR_LED_MSB:smpl_pkg::PWR_LED_LSB];
	assign led_dbg = power_and_led_control[smpl_pkg::PWR_LED_DBG_BIT];
	// lit on link, blanked while traffic flows
	assign link_act = link_up && !activity;

	always_comb begin
		if (led_dbg) begin
			next_led_first = !device_ready;
			next_led_second = !energy_stretched;
		end else begin
			case (led_mode)
				smpl_pkg::LED_LINKACT_SPEED: begin
					next_led_first = link_act;
					next_led_second = speed_100;
				end
				smpl_pkg::LED_LINK_ACT: begin
					next_led_first = link_up;
					next_led_second = activity;
				end
				smpl_pkg::LED_LINKACT_DUPLEX: begin
					next_led_first = link_act;
					next_led_second = full_duplex;
				end
				smpl_pkg::LED_LINK_DUPLEX: begin
					next_led_first = link_up;
					next_led_second = full_duplex;
				end
				default: begin
					next_led_first = 1'b0;
					next_led_second = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			led_pin_first <= 1'b0;
			led_pin_second <= 1'b0;
		end else begin
			led_pin_first <= next_led_first;
			led_pin_second <= next_led_second;
		end
	end

	// ==================================================
	// checks
	chk_pause_fire_time: assert property (@(posedge clk) disable iff (rst)
		flow_ctrl_invalidate_req |-> $past(pause_cnt) == 32'(PAUSE_LIMIT_CYCLES - 1)
			&& $past(pause_active) && $past(pause_limit_en))
		else $error("flow control invalidate requested at wrong time");
	chk_pause_disabled: assert property (@(posedge clk) disable iff (rst)
		!pause_limit_en || !pause_active |=> !flow_ctrl_invalidate_req && pause_cnt == 32'd0)
		else $error("pause limit active while disabled or not paused");
	chk_fiber_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == smpl_pkg::ADDR_FIBER_THRESH |=>
			fiber_thresh_high_p2 == $past(reg_wdata[7]) && fiber_thresh_high_p1 == $past(reg_wdata[6]))
		else $error("fiber threshold select not taken from write");
	chk_tag_s1_d2: assert property (@(posedge clk) disable iff (rst)
		qry_valid && qry_untagged && qry_src_port == 2'd1 && qry_egress_port == 2'd2
			|=> qry_insert == $past(source_vlan_tag_insert[5]))
		else $error("port 1 to port 2 tag decision wrong");
	chk_tag_s2_d3: assert property (@(posedge clk) disable iff (rst)
		qry_valid && qry_untagged && qry_src_port == 2'd2 && qry_egress_port == 2'd3
			|=> qry_insert == $past(source_vlan_tag_insert[2]))
		else $error("port 2 to port 3 tag decision wrong");
	chk_tag_s3_d1: assert property (@(posedge clk) disable iff (rst)
		qry_valid && qry_src_port == 2'd3 && qry_egress_port == 2'd1
			|=> qry_insert == ($past(qry_untagged) && $past(source_vlan_tag_insert[1])))
		else $error("port 3 to port 1 tag decision wrong");
	chk_pwr_bits_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == smpl_pkg::ADDR_PWR_LED |=> cpu_if_clk_pd_en == $past(reg_wdata[7])
			&& switch_clk_pd_en == $past(reg_wdata[6]) && pll_pd_en == $past(reg_wdata[2]))
		else $error("power-down enables not taken from write");
	chk_led_link_mode: assert property (@(posedge clk) disable iff (rst)
		!led_dbg && led_mode == 2'b11 |=> led_pin_first == $past(link_up)
			&& led_pin_second == $past(full_duplex))
		else $error("led link/duplex mode wrong");
	chk_led_debug: assert property (@(posedge clk) disable iff (rst)
		led_dbg |=> led_pin_first == !$past(device_ready) && led_pin_second == !$past(energy_stretched))
		else $error("led debug output not inverted signals");
	chk_sleep_needs_ed: assert property (@(posedge clk) disable iff (rst)
		power_mode != 2'b01 |=> !low_power_state)
		else $error("low power state outside energy detect mode");
	chk_sleep_rst_value: assert property (@(posedge clk)
		$fell(rst) |-> sleep_delay == 8'h50)
		else $error("sleep delay reset value wrong");
	cov_pause_fire: cover property (@(posedge clk) disable iff (rst) flow_ctrl_invalidate_req);
	cov_tag_insert: cover property (@(posedge clk) disable iff (rst) qry_valid ##1 qry_insert);
	cov_led_debug: cover property (@(posedge clk) disable iff (rst) led_dbg ##1 led_pin_second);
	cov_low_power: cover property (@(posedge clk) disable iff (rst) $rose(low_power_state));
endmodule : smpl_switch_misc_ctrl
`default_nettype wire

// >>> testbench/smpl_testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// shortened counts
	localparam int unsigned PAUSE_CYC = 8;
	localparam int unsigned UNIT_CYC = 4;
	// ==================================================
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	logic pause_active, flow_ctrl_invalidate_req;
	logic fiber_thresh_high_p1, fiber_thresh_high_p2;
	logic [5:0] tag_insert_map;
	logic qry_valid, qry_untagged, qry_insert;
	logic [1:0] qry_src_port, qry_egress_port;
	logic cpu_if_clk_pd_en, switch_clk_pd_en, pll_pd_en;
	logic [1:0] power_mode;
	logic energy_detected, low_power_state;
	logic link_up, activity, speed_100, full_duplex, energy_stretched, device_ready;
	logic led_pin_first, led_pin_second;
	int miscompares = 0;
	int checks = 0;
	int seed = 94;
	logic [7:0] adrs [5] = '{8'hbd, 8'hc0, 8'hc2, 8'hc3, 8'hc4};
	logic [7:0] rsts [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50};
	logic [7:0] msks [5] = '{8'hff, 8'hc0, 8'h3f, 8'hff, 8'hff};

	always #2 clk = ~clk;

	smpl_switch_misc_ctrl #(
		.PAUSE_LIMIT_CYCLES(PAUSE_CYC),
		.SLEEP_UNIT_CYCLES(UNIT_CYC)
	) smpl_switch_misc_ctrl_i (
		.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pause_active(pause_active), .flow_ctrl_invalidate_req(flow_ctrl_invalidate_req),
		.fiber_thresh_high_p1(fiber_thresh_high_p1),
		.fiber_thresh_high_p2(fiber_thresh_high_p2),
		.tag_insert_map(tag_insert_map), .qry_valid(qry_valid),
		.qry_src_port(qry_src_port), .qry_egress_port(qry_egress_port),
		.qry_untagged(qry_untagged), .qry_insert(qry_insert),
		.cpu_if_clk_pd_en(cpu_if_clk_pd_en), .switch_clk_pd_en(switch_clk_pd_en),
		.pll_pd_en(pll_pd_en), .power_mode(power_mode),
		.energy_detected(energy_detected), .low_power_state(low_power_state),
		.link_up(link_up), .activity(activity), .speed_100(speed_100),
		.full_duplex(full_duplex), .energy_stretched(energy_stretched),
		.device_ready(device_ready),
		.led_pin_first(led_pin_first), .led_pin_second(led_pin_second)
	);

	// ==================================================
	// checking and ending
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// ==================================================
	// register port, entered just after a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// one idle edge so the next strobe never rises in this time step
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
		@(negedge clk);
	endtask : rd

	// ==================================================
	// expectations
	function automatic logic [1:0] led_exp(input logic [2:0] m, input logic [5:0] s);
		// s = {link, act, speed, duplex, energy, ready}
		if (m[2])
			return {~s[0], ~s[1]};
		case (m[1:0])
			2'b00: return {s[5] & ~s[4], s[3]};
			2'b01: return {s[5], s[4]};
			2'b10: return {s[5] & ~s[4], s[2]};
			default: return {s[5], s[2]};
		endcase
	endfunction : led_exp

	function automatic logic tag_exp(input logic [5:0] map, input logic [3:0] sd);
		case (sd)
			4'h6: return map[5];
			4'h7: return map[4];
			4'h9: return map[3];
			4'hb: return map[2];
			4'hd: return map[1];
			4'he: return map[0];
			default: return 1'b0;
		endcase
	endfunction : tag_exp

	// pause held for hi cycles except a one-cycle gap at gap_at
	task automatic pause_run(input int hi, input int gap_at, output int pulses, output int first);
		pulses = 0;
		first = -1;
		for (int i = 0; i < hi; i++) begin
			pause_active = (i != gap_at);
			@(negedge clk);
			if (flow_ctrl_invalidate_req === 1'b1) begin
				if (first < 0)
					first = i;
				pulses++;
			end
		end
		pause_active = 1'b0;
		@(negedge clk);
	endtask : pause_run

	// ==================================================
	// main sequence
	initial begin
		logic [7:0] d, v;
		logic [5:0] s;
		int p, f, n;
		{reg_addr, reg_wdata, reg_wr, reg_rd, pause_active, qry_valid} = '0;
		{qry_src_port, qry_egress_port, qry_untagged, energy_detected} = '0;
		{link_up, activity, speed_100, full_duplex, energy_stretched, device_ready} = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(adrs[i], v);
			check("reset value", v, rsts[i]);
		end
		wr(8'hbe, 8'hff);
		rd(8'hbe, v);
		check("unmapped read", v, 8'h00);
		repeat (8) begin
			for (int i = 0; i < 5; i++) begin
				d = 8'($random(seed));
				wr(adrs[i], d);
				rd(adrs[i], v);
				check("read back", v, d & msks[i]);
				if (i == 1)
					check("fiber", {fiber_thresh_high_p2, fiber_thresh_high_p1}, d[7:6]);
				if (i == 2)
					check("tag map", tag_insert_map, d[5:0]);
				if (i == 3) begin
					check("cpu pd", cpu_if_clk_pd_en, d[7]);
					check("switch pd", switch_clk_pd_en, d[6]);
					check("pll pd", pll_pd_en, d[2]);
					check("power mode", power_mode, d[1:0]);
				end
			end
		end
		for (int m = 0; m < 8; m++) begin
			wr(smpl_pkg::ADDR_PWR_LED, {2'b00, m[1:0], m[2], 3'b000});
			repeat (6) begin
				s = 6'($random(seed));
				{link_up, activity, speed_100, full_duplex, energy_stretched, device_ready} = s;
				@(negedge clk);
				check("led pins", {led_pin_first, led_pin_second}, led_exp(m[2:0], s));
			end
		end
		repeat (3) begin
			d = 8'($random(seed));
			wr(smpl_pkg::ADDR_TAG_INSERT, d);
			// back to back queries: the strobe stays up for the whole sweep
			qry_valid = 1'b1;
			for (int q = 0; q < 32; q++) begin
				{qry_untagged, qry_src_port, qry_egress_port} = 5'(q);
				@(negedge clk);
				check("tag insert", qry_insert, qry_untagged & tag_exp(d[5:0], 4'(q)));
			end
			qry_valid = 1'b0;
		end
		wr(smpl_pkg::ADDR_PAUSE_LIMIT, 8'h01);
		pause_run(30, -1, p, f);
		check("pause pulses", 8'(p), 8'h01);
		check("pause moment", 8'(f), 8'(PAUSE_CYC - 1));
		// after the gap only seven pause edges follow: one short of the limit
		pause_run(13, 5, p, f);
		check("pause broken", 8'(p), 8'h00);
		wr(smpl_pkg::ADDR_PAUSE_LIMIT, 8'h80);
		pause_run(30, -1, p, f);
		check("pause high bit", 8'(p), 8'h01);
		wr(smpl_pkg::ADDR_PAUSE_LIMIT, 8'h00);
		pause_run(30, -1, p, f);
		check("pause off", 8'(p), 8'h00);
		energy_detected = 1'b1;
		wr(smpl_pkg::ADDR_SLEEP_DELAY, 8'h02);
		wr(smpl_pkg::ADDR_PWR_LED, 8'h01);
		energy_detected = 1'b0;
		n = 0;
		while (low_power_state !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 40) begin
				miscompares++;
				conclude();
			end
		end
		check("sleep entry", 8'(n >= 2 * UNIT_CYC && n <= 2 * UNIT_CYC + 3), 8'h01);
		energy_detected = 1'b1;
		repeat (2) @(negedge clk);
		check("wake", low_power_state, 8'h00);
		v = 8'h00;
		for (int i = 0; i < 14; i++) begin
			energy_detected = (i == 6);
			@(negedge clk);
			v = v | 8'(low_power_state);
		end
		check("idle restart", v, 8'h00);
		wr(smpl_pkg::ADDR_PWR_LED, 8'h02);
		energy_detected = 1'b0;
		repeat (20) @(negedge clk);
		check("other mode", low_power_state, 8'h00);
		conclude();
	end
endmodule : testbench
`default_nettype wire
